// ===== input_noise_filter.sv
`timescale 1ns/100ps
`include "tc_defs.svh"

module input_noise_filter (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level in, already synchronised
   input wire logic level_in,
   input wire logic bypass,
   // Filtered level
   output logic level_out
);

   logic [3:0] stable_q;

   // ----------------------------------------
   // Stability counter
   // ----------------------------------------
   // A level must hold for a number of clk periods between the reject
   // and the guaranteed width before it is passed on.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stable_q <= 4'h0;
      end else if (level_in == level_out) begin
         stable_q <= 4'h0;
      end else begin
         stable_q <= stable_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_out <= 1'b0;
      end else if (bypass) begin
         level_out <= level_in; // [RL12]
      end else if (stable_q == `TC_FILT_CYC - 4'h1 && level_in != level_out) begin
         level_out <= level_in; // [RL11]
      end
   end

endmodule

// ===== tc_defs.svh
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH

// ----------------------------------------
// Register offsets (byte wide registers)
// ----------------------------------------
`define TC_ADDR_CTRL 3'h0
`define TC_ADDR_CMPA_LO 3'h1
`define TC_ADDR_CMPA_HI 3'h2
`define TC_ADDR_CAPB_LO 3'h3
`define TC_ADDR_CAPB_HI 3'h4
`define TC_ADDR_CNT_LO 3'h5
`define TC_ADDR_CNT_HI 3'h6
`define TC_ADDR_STATUS 3'h7

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TC_MODE_LSB 0
`define TC_MODE_MSB 1
`define TC_SRC_LSB 2
`define TC_SRC_MSB 3
`define TC_START_LSB 4
`define TC_START_MSB 5
`define TC_ACAP_BIT 6
`define TC_STOPSEL_BIT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TC_CTRL_RST 8'h00
`define TC_CMPA_RST 16'hffff
`define TC_CAPB_RST 16'h0000

// ----------------------------------------
// Prescaler exponents (tick = clk / 2**n)
// ----------------------------------------
`define TC_DIV_C00 4'd11
`define TC_DIV_C00_X2 4'd12
`define TC_DIV_C01 4'd7
`define TC_DIV_C01_X2 4'd8
`define TC_DIV_C10 4'd3
`define TC_DIV_C10_X2 4'd4
`define TC_DIV_SLOW 4'd3

// ----------------------------------------
// Input noise filter, in clk periods
// ----------------------------------------
`define TC_FILT_REJECT_PER 4
`define TC_FILT_MIN_PER 12
`define TC_FILT_CYC 4'd8

`endif

// ===== tc_pkg.sv
package tc_pkg;

   typedef enum logic [1:0] {
      OPM_TIMER = 2'b00,
      OPM_WINDOW = 2'b01,
      OPM_PULSE = 2'b10,
      OPM_PPG = 2'b11
   } op_mode_t;

   typedef enum logic [1:0] {
      START_STOP = 2'b00,
      START_CMD = 2'b01,
      START_RISE = 2'b10,
      START_FALL = 2'b11
   } start_t;

   typedef enum logic [1:0] {
      SRC_DIV_SLOW = 2'b00,
      SRC_DIV_MID = 2'b01,
      SRC_DIV_FAST = 2'b10,
      SRC_PIN = 2'b11
   } src_sel_t;

   typedef enum logic {
      TRG_IDLE = 1'b0,
      TRG_RUN = 1'b1
   } trig_state_t;

endpackage

// ===== tc_pulse_source.sv
`timescale 1ns/100ps

// ----------------------------------------
// Pulse source on the timer input pin
// ----------------------------------------
module tc_pulse_source (
   // Clock
   input wire logic clk,
   // Request
   input wire logic go,
   input wire logic [7:0] level_len,
   input wire logic [3:0] pulses,
   input wire logic [3:0] glitch_len,
   // Pin
   output logic pin,
   output logic busy
);
   int i;

   // Each pulse level is held for level_len clocks; a nonzero glitch_len puts a glitch
   // of glitch_len clocks before each pulse, which the filter throws away only if it is short enough
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            for (i = 0; i < pulses; i++) begin
               if (glitch_len != 0) begin
                  pin <= 1'b1;
                  repeat (glitch_len) @(posedge clk);
                  pin <= 1'b0;
                  repeat (level_len) @(posedge clk);
               end
               pin <= 1'b1;
               repeat (level_len) @(posedge clk);
               pin <= 1'b0;
               repeat (level_len) @(posedge clk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule

// ===== tc_unused.sv
`timescale 1ns/100ps

// ===== trigger_event_timer_counter.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/100ps
`include "tc_defs.svh"

// What this block does
// [RL1] Six modes exist; only mode code 00 counts here, others hold counter cleared.
// [RL2] Timer mode counts source ticks; compare A match interrupts, clears, continues.
// [RL3] Auto-capture enable copies the counter into capture B each source tick.
// [RL4] Software waits one source tick after enabling capture before first read.
// [RL5] Software reads capture B only while running with capture enabled.
// [RL6] External trigger mode idles until the chosen pin edge, then counts ticks.
// [RL7] External trigger match clears, halts and interrupts, for both stop settings.
// [RL8] Stop select 1: opposite edge before match clears and halts, no interrupt.
// [RL9] Stop select 1: halted counter restarts from zero on next trigger edge.
// [RL10] Stop select 0: opposite edges ignored; trigger edges ignored while counting.
// [RL11] Pin filter rejects pulses up to four clocks; twelve guarantee detection.
// [RL12] Low-frequency modes bypass the filter; pulses need one machine cycle.
// [RL13] Event mode counts the chosen pin edge; match clears, interrupts, continues.
// [RL14] Event mode match is evaluated on the edge opposite the counting edge.
// [RL15] Source holds each pin level for at least two machine cycles.
// [RL16] Event mode auto-capture behaves as in timer mode.
// [RL17] Start control: 00 stop/clear, 01 command, 10 rising, 11 falling.
// [RL18] Source codes 00..10 are divided clocks, 11 the pin; slow allows 00.
// [RL19] Compare A loads at the first source tick after its upper byte write; while stopped it loads on the next clock.
// [RL20] Software changes configuration only while start control is 00.
// [RL21] Counter, compare A and capture B are sixteen bits, full equality compare.
// [RL22] Mode 00 covers timer, trigger and event; start and source choose.

module trigger_event_timer_counter (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Clock mode
   input wire logic low_freq_mode,
   input wire logic prescaler_stage_select,
   // Pin and event
   input wire logic timer_input_pin,
   output logic timer_match_interrupt
);

   logic rst_meta_q, rst_n_q;
   logic pin_meta_q, pin_sync_q, pin_filt, pin_prev_q;
   logic [11:0] pre_q;
   logic [7:0] ctrl_q;
   logic [7:0] cmpa_lo_q;
   logic [7:0] pend_hi_q;
   logic [15:0] cmpa_q, cnt_q, capb_q;
   logic load_pend_q;
   tc_pkg::trig_state_t trg_q;
   logic [3:0] div_exp;
   logic [11:0] div_mask;
   logic div_tick, rise, fall, cnt_edge, opp_edge, trig_edge;
   logic timer_mode, ext_mode, event_mode, active, src_tick, match;
   tc_pkg::start_t start;
   tc_pkg::src_sel_t src;

   // ----------------------------------------
   // Reset release and pin synchroniser
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end else begin
         pin_meta_q <= timer_input_pin;
         pin_sync_q <= pin_meta_q;
      end
   end

   input_noise_filter u_filter (
      .clk(clk),
      .rst_n(rst_n_q),
      .level_in(pin_sync_q),
      .bypass(low_freq_mode), // [RL12]
      .level_out(pin_filt) // [RL11]
   );

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= pin_filt;
      end
   end

   assign rise = pin_filt & ~pin_prev_q;
   assign fall = ~pin_filt & pin_prev_q;

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   assign start = tc_pkg::start_t'(ctrl_q[`TC_START_MSB:`TC_START_LSB]);
   assign src = tc_pkg::src_sel_t'(ctrl_q[`TC_SRC_MSB:`TC_SRC_LSB]);
   // Only the combined timer mode code counts here
   assign active = ctrl_q[`TC_MODE_MSB:`TC_MODE_LSB] == tc_pkg::OPM_TIMER
      && start != tc_pkg::START_STOP; // [RL1] [RL22]
   assign event_mode = active && src == tc_pkg::SRC_PIN; // [RL22]
   assign timer_mode = active && !event_mode
      && start == tc_pkg::START_CMD; // [RL22]
   assign ext_mode = active && !event_mode && start[1]; // [RL22]
   // Command start on the pin source counts rising edges
   assign cnt_edge = (start == tc_pkg::START_FALL) ? fall : rise; // [RL13]
   assign opp_edge = (start == tc_pkg::START_FALL) ? rise : fall; // [RL14]
   assign trig_edge = cnt_edge; // [RL6]

   // ----------------------------------------
   // Prescaler and source tick
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pre_q <= 12'h000;
      end else begin
         pre_q <= pre_q + 12'h001;
      end
   end

   always_comb begin
      div_exp = `TC_DIV_C00;
      unique case (src)
         tc_pkg::SRC_DIV_SLOW: begin
            if (low_freq_mode) begin
               div_exp = `TC_DIV_SLOW;
            end else begin
               div_exp = prescaler_stage_select ? `TC_DIV_C00_X2 : `TC_DIV_C00;
            end
         end
         tc_pkg::SRC_DIV_MID: begin
            div_exp = prescaler_stage_select ? `TC_DIV_C01_X2 : `TC_DIV_C01;
         end
         tc_pkg::SRC_DIV_FAST: begin
            div_exp = prescaler_stage_select ? `TC_DIV_C10_X2 : `TC_DIV_C10;
         end
         tc_pkg::SRC_PIN: begin
            div_exp = `TC_DIV_C00;
         end
      endcase
   end

   assign div_mask = 12'((13'h0001 << div_exp) - 13'h0001);
   // Divided codes other than 00 give no tick in the low-frequency modes
   assign div_tick = (pre_q & div_mask) == div_mask
      && (!low_freq_mode || src == tc_pkg::SRC_DIV_SLOW); // [RL18]
   assign src_tick = event_mode ? cnt_edge : div_tick; // [RL18]
   assign match = cnt_q == cmpa_q; // [RL21]

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= `TC_CTRL_RST;
      end else if (reg_write && reg_addr == `TC_ADDR_CTRL) begin
         ctrl_q <= reg_wdata;
      end
   end

   // The lower byte waits in a shadow so a half write never reaches compare
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cmpa_lo_q <= 8'h00;
         pend_hi_q <= 8'h00;
         load_pend_q <= 1'b0;
         cmpa_q <= `TC_CMPA_RST;
      end else begin
         if (reg_write && reg_addr == `TC_ADDR_CMPA_LO) begin
            cmpa_lo_q <= reg_wdata;
         end
         // A fresh upper byte write re-arms the load and wins over a tick
         if (reg_write && reg_addr == `TC_ADDR_CMPA_HI) begin
            load_pend_q <= 1'b1; // [RL19]
            pend_hi_q <= reg_wdata;
         end else if (load_pend_q && (src_tick || !active)) begin
            load_pend_q <= 1'b0; // [RL19]
            cmpa_q <= {pend_hi_q, cmpa_lo_q}; // [RL19]
         end
      end
   end

   // ----------------------------------------
   // Counter, trigger state and match event
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cnt_q <= 16'h0000;
         trg_q <= tc_pkg::TRG_IDLE;
         timer_match_interrupt <= 1'b0;
      end else begin
         timer_match_interrupt <= 1'b0;
         if (!active) begin
            cnt_q <= 16'h0000; // [RL17] [RL1]
            trg_q <= tc_pkg::TRG_IDLE;
         end else if (event_mode) begin
            if (opp_edge && match) begin
               cnt_q <= 16'h0000; // [RL14]
               timer_match_interrupt <= 1'b1; // [RL13]
            end else if (cnt_edge) begin
               cnt_q <= cnt_q + 16'h0001; // [RL13]
            end
         end else if (ext_mode) begin
            unique case (trg_q)
               tc_pkg::TRG_IDLE: begin
                  cnt_q <= 16'h0000;
                  if (trig_edge) begin
                     trg_q <= tc_pkg::TRG_RUN; // [RL6] [RL9]
                  end
               end
               tc_pkg::TRG_RUN: begin
                  if (src_tick && match) begin
                     cnt_q <= 16'h0000; // [RL7]
                     trg_q <= tc_pkg::TRG_IDLE;
                     timer_match_interrupt <= 1'b1;
                  end else if (ctrl_q[`TC_STOPSEL_BIT] && opp_edge) begin
                     cnt_q <= 16'h0000; // [RL8]
                     trg_q <= tc_pkg::TRG_IDLE;
                  end else if (src_tick) begin
                     cnt_q <= cnt_q + 16'h0001; // [RL10]
                  end
               end
            endcase
         end else if (timer_mode && src_tick) begin
            if (match) begin
               cnt_q <= 16'h0000; // [RL2]
               timer_match_interrupt <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 16'h0001; // [RL2]
            end
         end
      end
   end

   // ----------------------------------------
   // Auto-capture
   // ----------------------------------------
   // Capture follows the counter one tick late; a read right after the
   // enable bit is set may still show the old value.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         capb_q <= `TC_CAPB_RST;
      end else if (ctrl_q[`TC_ACAP_BIT] && (timer_mode || event_mode)
         && src_tick) begin
         capb_q <= cnt_q; // [RL3] [RL16] [RL4] [RL5]
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            `TC_ADDR_CTRL: reg_rdata <= ctrl_q;
            `TC_ADDR_CMPA_LO: reg_rdata <= cmpa_q[7:0];
            `TC_ADDR_CMPA_HI: reg_rdata <= cmpa_q[15:8];
            `TC_ADDR_CAPB_LO: reg_rdata <= capb_q[7:0];
            `TC_ADDR_CAPB_HI: reg_rdata <= capb_q[15:8];
            `TC_ADDR_CNT_LO: reg_rdata <= cnt_q[7:0];
            `TC_ADDR_CNT_HI: reg_rdata <= cnt_q[15:8];
            `TC_ADDR_STATUS: reg_rdata <= {6'h00, load_pend_q,
               ext_mode ? trg_q == tc_pkg::TRG_RUN : active};
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_q);

   sequence s_ext_running;
      ext_mode && trg_q == tc_pkg::TRG_RUN;
   endsequence

   sequence s_halted;
      trg_q == tc_pkg::TRG_IDLE && cnt_q == 16'h0000;
   endsequence

   a_stop_clears: assert property ( // [RL17]
      !active |=> cnt_q == 16'h0000)
      else $error("counter not cleared while stopped");

   a_timer_match: assert property ( // [RL2]
      timer_mode && src_tick && match
      |=> timer_match_interrupt && cnt_q == 16'h0000)
      else $error("timer match did not clear and interrupt");

   a_capture_copy: assert property ( // [RL3]
      ctrl_q[`TC_ACAP_BIT] && timer_mode && src_tick
      |=> capb_q == $past(cnt_q))
      else $error("capture missed counter value");

   a_ext_match_halt: assert property ( // [RL7]
      s_ext_running ##0 (src_tick && match && ext_mode)
      |=> s_halted ##0 timer_match_interrupt)
      else $error("trigger match did not halt with interrupt");

   a_opp_edge_stop: assert property ( // [RL8]
      s_ext_running ##0 (ctrl_q[`TC_STOPSEL_BIT] && opp_edge
      && !(src_tick && match))
      |=> s_halted ##0 !timer_match_interrupt)
      else $error("opposite edge stop wrong");

   a_trig_restart: assert property ( // [RL9]
      ext_mode && trg_q == tc_pkg::TRG_IDLE && trig_edge
      |=> trg_q == tc_pkg::TRG_RUN && cnt_q == 16'h0000)
      else $error("trigger edge did not restart counter");

   a_event_count: assert property ( // [RL13]
      event_mode && cnt_edge |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("event edge not counted");

   a_event_match: assert property ( // [RL14]
      event_mode && opp_edge && match
      |=> cnt_q == 16'h0000 && timer_match_interrupt)
      else $error("event match not taken on opposite edge");

   a_cmp_load_hold: assert property ( // [RL19]
      !load_pend_q && !(reg_write && reg_addr == `TC_ADDR_CMPA_HI)
      |=> $stable(cmpa_q) [*2])
      else $error("compare changed without upper byte write");

   a_irq_single: assert property ( // [RL7]
      timer_match_interrupt |=> !timer_match_interrupt)
      else $error("match interrupt longer than one cycle");

endmodule

// ===== trigger_event_timer_counter_bench.sv
`timescale 1ns/100ps
`include "tc_defs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
 $display("[ERR] %0t got %h expected %h", $time, a, b); end end

module trigger_event_timer_counter_bench;
   localparam logic [1:0] SRCS [4] = '{2'b10, 2'b10, 2'b00, 2'b01};
   localparam int DIVS [4] = '{8, 16, 8, 128};
   localparam logic [3:0] LFS = 4'b0100;
   localparam logic [3:0] STS = 4'b0010;
   localparam logic [3:0] STOPS = 4'b0110;
   localparam logic [7:0] LVS [4] = '{8'd12, 8'd12, 8'd60, 8'd60};
   localparam int EXTS [4] = '{1, 0, 2, 2};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic low_freq_mode = 1'b0;
   logic prescaler_stage_select = 1'b0;
   logic [7:0] reg_rdata;
   logic timer_input_pin;
   logic timer_match_interrupt;
   logic go = 1'b0;
   logic [7:0] lvl = 8'h0e;
   logic [3:0] npls = 4'h0;
   logic [3:0] glen = 4'h0;
   logic busy;
   logic rd_seen = 1'b0;
   logic [7:0] e;
   logic [7:0] expq [$];
   int mismatches = 0;
   int num_checks = 0;
   int seed = 26;
   int ints = 0;
   int cyc = 0;
   int k, m, i0, t0, t1, cv;

   always #5 clk = ~clk;

   trigger_event_timer_counter trigger_event_timer_counter_inst (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .low_freq_mode(low_freq_mode),
      .prescaler_stage_select(prescaler_stage_select),
      .timer_input_pin(timer_input_pin),
      .timer_match_interrupt(timer_match_interrupt));

   tc_pulse_source tc_pulse_source_inst (
      .clk(clk), .go(go), .level_len(lvl), .pulses(npls),
      .glitch_len(glen), .pin(timer_input_pin), .busy(busy));

   // ----------------------------------------
   // Output watcher
   // ----------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (timer_match_interrupt === 1'b1) ints <= ints + 1;
      rd_seen <= reg_read;
      if (rd_seen) begin
         e = expq.pop_front();
         `CHK(reg_rdata, e)
      end
   end

   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] x);
      expq.push_back(x);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
   endtask

   // Configuration only changes while stopped, hence the two stop writes
   task automatic go_cfg(input logic [7:0] c);
      wr(`TC_ADDR_CTRL, 8'h00);
      wr(`TC_ADDR_CTRL, c & 8'hcf);
      wr(`TC_ADDR_CTRL, c);
   endtask

   task automatic cmpa(input logic [15:0] v);
      wr(`TC_ADDR_CMPA_LO, v[7:0]);
      wr(`TC_ADDR_CMPA_HI, v[15:8]);
      repeat (2) @(posedge clk);
   endtask

   task automatic pulses(input logic [7:0] lv, input logic [3:0] n,
                         input logic [3:0] g);
      int w;
      w = 0;
      lvl <= lv;
      npls <= n;
      glen <= g;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy === 1'b1 && w < 5000) begin
         @(posedge clk);
         w++;
      end
      // Filter and edge detect latency before the last edge lands
      repeat (40) @(posedge clk);
   endtask

   task automatic wint(output int t);
      int w;
      w = 0;
      @(posedge clk);
      while (timer_match_interrupt !== 1'b1 && w < 3000) begin
         @(posedge clk);
         w++;
      end
      if (w >= 3000) begin
         mismatches++;
         $display("[ERR] %0t no match pulse", $time);
      end
      t = cyc;
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(`TC_ADDR_CTRL, `TC_CTRL_RST);
      rd(`TC_ADDR_CMPA_LO, `TC_CMPA_RST & 16'h00ff);
      rd(`TC_ADDR_CMPA_HI, `TC_CMPA_RST >> 8);
      rd(`TC_ADDR_CAPB_LO, `TC_CAPB_RST & 16'h00ff);
      rd(`TC_ADDR_CNT_LO, 8'h00);
      rd(`TC_ADDR_STATUS, 8'h00);
      wr(`TC_ADDR_CMPA_LO, 8'h34);
      repeat (2) @(posedge clk);
      rd(`TC_ADDR_CMPA_LO, 8'hff);
      wr(`TC_ADDR_CMPA_HI, 8'h12);
      rd(`TC_ADDR_STATUS, 8'h02);
      repeat (2) @(posedge clk);
      rd(`TC_ADDR_CMPA_LO, 8'h34);
      rd(`TC_ADDR_CMPA_HI, 8'h12);
      wr(`TC_ADDR_CNT_LO, 8'h55);
      rd(`TC_ADDR_CNT_LO, 8'h00);
      $display("test registers done");
      // Second match interval is exact; the first depends on prescaler phase
      for (k = 0; k < 4; k++) begin
         wr(`TC_ADDR_CTRL, 8'h00);
         low_freq_mode <= LFS[k];
         prescaler_stage_select <= STS[k];
         cv = 2 + ($random(seed) & 3);
         cmpa(cv[15:0]);
         go_cfg({4'b0001, SRCS[k], 2'b00});
         wint(t0);
         wint(t1);
         `CHK(t1 - t0, (cv + 1) * DIVS[k])
      end
      wr(`TC_ADDR_CTRL, 8'h00);
      low_freq_mode <= 1'b0;
      prescaler_stage_select <= 1'b0;
      $display("test timer done");
      for (m = 1; m < 4; m++) begin
         go_cfg({4'b0001, 2'b10, m[1:0]});
         i0 = ints;
         repeat (100) @(posedge clk);
         `CHK(ints - i0, 0)
         rd(`TC_ADDR_CNT_LO, 8'h00);
      end
      $display("test other modes done");
      cmpa(16'h0005);
      for (k = 0; k < 4; k++) begin
         go_cfg({STOPS[k], 1'b0, 2'b10, 2'b10, 2'b00});
         i0 = ints;
         pulses(LVS[k], 4'd2, 4'd0);
         `CHK(ints - i0, EXTS[k])
         rd(`TC_ADDR_CNT_LO, 8'h00);
      end
      $display("test trigger done");
      cmpa(16'h0002);
      for (k = 0; k < 2; k++) begin
         go_cfg({2'b00, k[0] ? 2'b11 : 2'b10, 2'b11, 2'b00});
         i0 = ints;
         pulses(8'd14, 4'd6, 4'd3);
         `CHK(ints - i0, k[0] ? 2 : 3)
      end
      cmpa(16'hffff);
      go_cfg({2'b01, 2'b10, 2'b11, 2'b00});
      pulses(8'd14, 4'd5, 4'd0);
      rd(`TC_ADDR_CNT_LO, 8'h05);
      rd(`TC_ADDR_CAPB_LO, 8'h04);
      rd(`TC_ADDR_CAPB_HI, 8'h00);
      repeat (3) @(posedge clk);
      $display("test event done");
      close_out();
   end

   initial begin
      #400000;
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
endmodule
